/* hdl/dtc_params.svh */
// Register offsets, field positions, reset values and counts for the timers
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Byte addresses of the byte-wide registers, one per bus word
`define DTC_ADR_MODE 8'h80
`define DTC_ADR_CLKC 8'h84
`define DTC_ADR_RUNF 8'h88
`define DTC_ADR_GCFG 8'h8C
`define DTC_ADR_LOWA 8'h90
`define DTC_ADR_HIGHA 8'h94
`define DTC_ADR_LOWB 8'h98
`define DTC_ADR_HIGHB 8'h9C
`define DTC_ADR_ISTS 8'hA0
`define DTC_ADR_IMSK 8'hA4

// Field positions in timer_run_flags
`define DTC_RUN_A 4
`define DTC_FLAG_A 5
`define DTC_RUN_B 6
`define DTC_FLAG_B 7

// Field positions in clock_choice_reg and ext_input_config_reg
`define DTC_PSC_LO 0
`define DTC_SYS_A 3
`define DTC_SYS_B 4
`define DTC_POL_A 3
`define DTC_POL_B 7

// Interrupt status and mask bit positions
`define DTC_IRQ_FA 0
`define DTC_IRQ_FB 1
`define DTC_IRQ_PB 2

// Reset values and count limits
`define DTC_RST_BYTE 8'h00
`define DTC_RST_WORD 32'h0000_0000
`define DTC_RST_IRQ 3'h0
`define DTC_MODE_SPLIT 2'h3
`define DTC_MAX13 13'h1FFF
`define DTC_BYTE_ONES 8'hFF
`define DTC_PSC_DIV0 8'h0C
`define DTC_PSC_DIV1 8'h04
`define DTC_PSC_DIV2 8'h30
`define DTC_PSC_DIV3 8'h08

`endif

/* hdl/dtc_pkg.sv */
// Types shared by the timer block
package dtc_pkg;

  // One timer's field in timer_mode_select_reg
  typedef struct packed {
    logic gate_en;
    logic cnt_sel;
    logic [1:0] mode;
  } dtc_tmode_t;

  // Whole mode register, timer B in the upper nibble
  typedef struct packed {
    dtc_tmode_t b;
    dtc_tmode_t a;
  } dtc_tmode_pair_t;

  // Result of one count step
  typedef struct packed {
    logic ovf;
    logic [7:0] high;
    logic [7:0] low;
  } dtc_step_t;

endpackage

/* hdl/dtc_pin_sync.sv */
// Three-stage pin synchroniser with agreed level and falling-edge pulse
`timescale 1ns/1ps

module dtc_pin_sync
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic fall_ff;
  logic nxt_level;
  logic nxt_fall;

  // Level only moves once stages two and three agree, which filters glitches
  always_comb
  begin
    nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;
    nxt_fall = level_ff & ~nxt_level;
  end

  // Stage one is read only by stage two
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      level_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
      fall_ff <= nxt_fall;
    end
  end

  assign level_o = level_ff;
  assign fall_o = fall_ff;

endmodule

/* hdl/dtc_top.sv */
// Two 8051-style counter/timers with a classic Wishbone register slave
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "dtc_params.svh"

module dtc_top
  import dtc_pkg::*;
#(
  parameter int ADR_W = 8,
  parameter int PSC_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic count_pin_a_i,
  input wire logic count_pin_b_i,
  input wire logic gate_input_a_i,
  input wire logic gate_input_b_i,
  output logic irq_o,
  output logic ovf_pulse_b_o
);

  // Prescale divide chosen by the two-bit field
  function automatic logic [PSC_W-1:0] psc_limit(input logic [1:0] f);
    logic [7:0] d;
    begin
      case (f)
        2'h0: d = `DTC_PSC_DIV0;
        2'h1: d = `DTC_PSC_DIV1;
        2'h2: d = `DTC_PSC_DIV2;
        default: d = `DTC_PSC_DIV3;
      endcase
      psc_limit = PSC_W'(d - 8'h01);
    end
  endfunction

  // One increment in modes 0 to 2; split mode is handled by the caller
  function automatic dtc_step_t step(input logic [1:0] md,
                                     input logic [7:0] lo,
                                     input logic [7:0] hi);
    logic [12:0] v13;
    logic [16:0] v16;
    begin
      step.ovf = 1'b0;
      step.high = hi;
      step.low = lo;
      v13 = {hi, lo[4:0]};
      v16 = {1'b0, hi, lo} + 17'h0_0001;
      case (md)
        2'h0:
        begin
          step.ovf = (v13 == `DTC_MAX13);
          v13 = v13 + 13'h0001;
          step.high = v13[12:5];
          step.low = {lo[7:5], v13[4:0]};
        end
        2'h1:
        begin
          step.ovf = v16[16];
          step.high = v16[15:8];
          step.low = v16[7:0];
        end
        2'h2:
        begin
          step.ovf = (lo == `DTC_BYTE_ONES);
          step.low = step.ovf ? hi : lo + 8'h01;
        end
        default: step.ovf = 1'b0;
      endcase
    end
  endfunction

  // Gate test shared by both timers
  function automatic logic gate_ok(input logic gate_en,
                                   input logic lvl,
                                   input logic pol);
    gate_ok = ~gate_en | (lvl == pol);
  endfunction

  dtc_tmode_pair_t mode_ff, nxt_mode;
  logic [7:0] clkc_ff, nxt_clkc, gcfg_ff, nxt_gcfg;
  logic run_a_ff, run_b_ff, flag_a_ff, flag_b_ff;
  logic nxt_run_a, nxt_run_b, nxt_flag_a, nxt_flag_b;
  logic [7:0] low_a_ff, high_a_ff, low_b_ff, high_b_ff;
  logic [7:0] nxt_low_a, nxt_high_a, nxt_low_b, nxt_high_b;
  logic [2:0] sts_ff, msk_ff, nxt_sts, nxt_msk;
  logic irq_ff, pulse_ff, nxt_irq, nxt_pulse;
  logic [PSC_W-1:0] psc_cnt_ff, nxt_psc_cnt;
  logic psc_tick_ff, nxt_psc_tick, ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic lvl_gate_a, lvl_gate_b, fall_a, fall_b;

  // Pins come from outside the clock domain
  dtc_pin_sync u_sync_pin_a (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(count_pin_a_i),
    .level_o(), .fall_o(fall_a));
  dtc_pin_sync u_sync_pin_b (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(count_pin_b_i),
    .level_o(), .fall_o(fall_b));
  dtc_pin_sync u_sync_gate_a (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(gate_input_a_i),
    .level_o(lvl_gate_a), .fall_o());
  dtc_pin_sync u_sync_gate_b (
    .clk_i(clk_i), .rst_i(rst_i), .pin_i(gate_input_b_i),
    .level_o(lvl_gate_b), .fall_o());

  // Prescaler: free-running, one tick per divide period
  always_comb
  begin
    nxt_psc_tick = 1'b0;
    nxt_psc_cnt = psc_cnt_ff + PSC_W'(1);
    if (psc_cnt_ff >= psc_limit(clkc_ff[`DTC_PSC_LO +: 2]))
    begin
      nxt_psc_cnt = '0;
      nxt_psc_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      psc_cnt_ff <= '0;
      psc_tick_ff <= 1'b0;
    end
    else
    begin
      psc_cnt_ff <= nxt_psc_cnt;
      psc_tick_ff <= nxt_psc_tick;
    end
  end

  // Bus strobes: access happens on the edge that raises ack
  logic req, wr, rd;
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;

  // Counting, flags, registers and bus answer
  always_comb
  begin
    logic split, tmr_a, tmr_b, src_a, src_b, en_a, en_b;
    logic ovf_hi, ovf_lo, set_a, set_b;
    logic [7:0] wd;
    dtc_step_t sa, sb;
    split = (mode_ff.a.mode == `DTC_MODE_SPLIT);
    wd = wb_dat_i[7:0];
    // Timebase when not counting the pin
    tmr_a = clkc_ff[`DTC_SYS_A] | psc_tick_ff;
    tmr_b = clkc_ff[`DTC_SYS_B] | psc_tick_ff;
    src_a = mode_ff.a.cnt_sel ? fall_a : tmr_a;
    // In split mode B may not see its pin
    src_b = (mode_ff.b.cnt_sel & ~split) ? fall_b : tmr_b;
    en_a = run_a_ff & gate_ok(mode_ff.a.gate_en, lvl_gate_a,
                              gcfg_ff[`DTC_POL_A]);
    en_b = split ? (mode_ff.b.mode != `DTC_MODE_SPLIT)
                 : run_b_ff & gate_ok(mode_ff.b.gate_en, lvl_gate_b,
                                      gcfg_ff[`DTC_POL_B]);
    // Independent mode fields per timer
    sa = step(mode_ff.a.mode, low_a_ff, high_a_ff);
    sb = step(mode_ff.b.mode, low_b_ff, high_b_ff);
    nxt_low_a = low_a_ff;
    nxt_high_a = high_a_ff;
    nxt_low_b = low_b_ff;
    nxt_high_b = high_b_ff;
    ovf_lo = 1'b0;
    ovf_hi = 1'b0;
    set_a = 1'b0;
    set_b = 1'b0;
    nxt_pulse = 1'b0;
    if (split)
    begin
      // Two 8-bit halves of timer A
      if (en_a & src_a)
      begin
        nxt_low_a = low_a_ff + 8'h01;
        ovf_lo = (low_a_ff == `DTC_BYTE_ONES);
      end
      if (run_b_ff & tmr_a)
      begin
        nxt_high_a = high_a_ff + 8'h01;
        ovf_hi = (high_a_ff == `DTC_BYTE_ONES);
      end
      set_a = ovf_lo;
      set_b = ovf_hi;
    end
    else if (en_a & src_a)
    begin
      nxt_low_a = sa.low;
      nxt_high_a = sa.high;
      set_a = sa.ovf;
    end
    if (en_b & src_b & (mode_ff.b.mode != `DTC_MODE_SPLIT))
    begin
      nxt_low_b = sb.low;
      nxt_high_b = sb.high;
      nxt_pulse = sb.ovf;
      // While A is split, B's flag belongs to A's high byte
      if (!split)
        set_b = sb.ovf;
    end
    // Software writes override the count; run writes leave counts as is
    nxt_mode = mode_ff;
    nxt_clkc = clkc_ff;
    nxt_gcfg = gcfg_ff;
    nxt_msk = msk_ff;
    nxt_run_a = run_a_ff;
    nxt_run_b = run_b_ff;
    nxt_flag_a = flag_a_ff;
    nxt_flag_b = flag_b_ff;
    if (wr)
    begin
      case (wb_adr_i)
        `DTC_ADR_MODE: nxt_mode = dtc_tmode_pair_t'(wd);
        `DTC_ADR_CLKC: nxt_clkc = wd;
        `DTC_ADR_GCFG: nxt_gcfg = wd;
        `DTC_ADR_LOWA: nxt_low_a = wd;
        `DTC_ADR_HIGHA: nxt_high_a = wd;
        `DTC_ADR_LOWB: nxt_low_b = wd;
        `DTC_ADR_HIGHB: nxt_high_b = wd;
        `DTC_ADR_IMSK: nxt_msk = wd[2:0];
        `DTC_ADR_RUNF:
        begin
          nxt_run_a = wd[`DTC_RUN_A];
          nxt_run_b = wd[`DTC_RUN_B];
          nxt_flag_a = wd[`DTC_FLAG_A];
          nxt_flag_b = wd[`DTC_FLAG_B];
        end
        default: nxt_msk = msk_ff;
      endcase
    end
    // A hardware set beats a software clear in the same cycle
    nxt_flag_a = nxt_flag_a | set_a;
    nxt_flag_b = nxt_flag_b | set_b;
    // Sticky events, cleared by reading status; a new event still lands
    nxt_sts = ((rd && wb_adr_i == `DTC_ADR_ISTS) ? `DTC_RST_IRQ : sts_ff)
              | {nxt_pulse, set_b, set_a};
    nxt_irq = |(nxt_sts & nxt_msk);
    // Read data; unmapped addresses answer zero
    nxt_ack = req;
    nxt_dat = dat_ff;
    if (rd)
    begin
      nxt_dat = `DTC_RST_WORD;
      case (wb_adr_i)
        `DTC_ADR_MODE: nxt_dat[7:0] = mode_ff;
        `DTC_ADR_CLKC: nxt_dat[7:0] = clkc_ff;
        `DTC_ADR_GCFG: nxt_dat[7:0] = gcfg_ff;
        `DTC_ADR_LOWA: nxt_dat[7:0] = low_a_ff;
        `DTC_ADR_HIGHA: nxt_dat[7:0] = high_a_ff;
        `DTC_ADR_LOWB: nxt_dat[7:0] = low_b_ff;
        `DTC_ADR_HIGHB: nxt_dat[7:0] = high_b_ff;
        `DTC_ADR_ISTS: nxt_dat[2:0] = sts_ff;
        `DTC_ADR_IMSK: nxt_dat[2:0] = msk_ff;
        `DTC_ADR_RUNF: nxt_dat[7:4] = {flag_b_ff, run_b_ff,
                                       flag_a_ff, run_a_ff};
        default: nxt_dat = `DTC_RST_WORD;
      endcase
    end
  end

  // Everything above registered; control resets to zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_ff <= dtc_tmode_pair_t'(`DTC_RST_BYTE);
      clkc_ff <= `DTC_RST_BYTE;
      gcfg_ff <= `DTC_RST_BYTE;
      run_a_ff <= 1'b0;
      run_b_ff <= 1'b0;
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
      low_a_ff <= `DTC_RST_BYTE;
      high_a_ff <= `DTC_RST_BYTE;
      low_b_ff <= `DTC_RST_BYTE;
      high_b_ff <= `DTC_RST_BYTE;
      sts_ff <= `DTC_RST_IRQ;
      msk_ff <= `DTC_RST_IRQ;
      irq_ff <= 1'b0;
      pulse_ff <= 1'b0;
      ack_ff <= 1'b0;
      dat_ff <= `DTC_RST_WORD;
    end
    else
    begin
      mode_ff <= nxt_mode;
      clkc_ff <= nxt_clkc;
      gcfg_ff <= nxt_gcfg;
      run_a_ff <= nxt_run_a;
      run_b_ff <= nxt_run_b;
      flag_a_ff <= nxt_flag_a;
      flag_b_ff <= nxt_flag_b;
      low_a_ff <= nxt_low_a;
      high_a_ff <= nxt_high_a;
      low_b_ff <= nxt_low_b;
      high_b_ff <= nxt_high_b;
      sts_ff <= nxt_sts;
      msk_ff <= nxt_msk;
      irq_ff <= nxt_irq;
      pulse_ff <= nxt_pulse;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;
  assign irq_o = irq_ff;
  assign ovf_pulse_b_o = pulse_ff;

endmodule

/* testbench/dtc_props.sv */
// Bus and interrupt assertions for the timer block
`timescale 1ns/1ps
module dtc_props
#(
  parameter int ADR_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic ovf_pulse_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  // A live request from the master
  assign req = wb_cyc_i && wb_stb_i;
  a_ack_one_late: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_no_req: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");
  a_rd_upper_zero: assert property (wb_ack_o && !wb_we_i
    |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_runf_low_zero: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i == 8'h88 |-> wb_dat_o[3:0] == 4'h0)
    else $error("run flag low bits not zero");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i >= 8'hA8 |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Reset must silence ack, irq and the B overflow pulse by the next edge
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_o && !ovf_pulse_b_o)
    else $error("output active after reset");
  // Sticky status keeps the interrupt up until software touches the bus
  a_irq_holds: assert property (irq_o && !req && !$past(req)
    |=> irq_o)
    else $error("interrupt dropped without bus access");
endmodule

bind dtc_top dtc_props #(.ADR_W(ADR_W)) u_props (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq_o(irq_o), .ovf_pulse_b_o(ovf_pulse_b_o));

/* testbench/dtc_pin_model.sv */
// Count pin driver: one falling edge per request
`timescale 1ns/1ps
module dtc_pin_model
(
  input wire logic clk_i,
  input wire logic fire_i,
  output logic pin_o
);
  logic [3:0] left_ff = 4'h0;
  // Four cycles low then four high, so each level is sampled on four clock edges
  always_ff @(posedge clk_i)
  begin
    if (fire_i && left_ff == 4'h0)
      left_ff <= 4'h8;
    else if (left_ff != 4'h0)
      left_ff <= left_ff - 4'h1;
  end
  // Pin idles high like a pulled-up input
  assign pin_o = !(left_ff > 4'h4);
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the dual timer block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, pin_a, pin_b, pulse_b;
  logic fire_a = 1'b0;
  logic fire_b = 1'b0;
  logic gate_a = 1'b0;
  logic gate_b = 1'b0;
  int n_pulse_b = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [15:0] exp_q[$];
  logic [15:0] e;

  always #5 clk_i = ~clk_i;

  dtc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .count_pin_a_i(pin_a), .count_pin_b_i(pin_b),
    .gate_input_a_i(gate_a), .gate_input_b_i(gate_b), .irq_o(irq_o),
    .ovf_pulse_b_o(pulse_b));
  dtc_pin_model pin_a_m (.clk_i(clk_i), .fire_i(fire_a), .pin_o(pin_a));
  dtc_pin_model pin_b_m (.clk_i(clk_i), .fire_i(fire_b), .pin_o(pin_b));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One classic cycle, held until the edge that sees ack
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [7:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h00_0000, dat};
    // Only the watchdog ends a wait for ack
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat);
  endtask

  // Note the expectation, then read; the monitor compares it
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp,
                    input logic [7:0] msk);
    exp_q.push_back({msk, exp});
    bus(1'b0, adr, 8'h00);
  endtask

  // One falling edge on a count pin, then time for it to land
  task automatic pulse(input int t);
    @(posedge clk_i);
    if (t == 0)
      fire_a <= 1'b1;
    else
      fire_b <= 1'b1;
    @(posedge clk_i);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask

  // Oldest note against each answered read; upper bits must be zero
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check($sformatf("read %h", wb_adr_i),
            wb_dat_o & {24'hFF_FFFF, e[15:8]}, {24'h0, e[7:0] & e[15:8]});
    end

  // Counts timer B overflow pulses seen on the output
  always @(posedge clk_i)
    if (pulse_b === 1'b1)
      n_pulse_b++;

  initial
  begin
    logic [7:0] r;
    int t;
    int md;
    void'($urandom(32'h820c));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h88, 8'h00, 8'hFF);
    rd(8'h80, 8'h00, 8'hFF);
    rd(8'hB0, 8'h00, 8'hFF);
    wr(8'hA4, 8'h07);
    // Modes 0 to 2 on each timer, counted from the pin across the wrap
    for (t = 0; t < 2; t++)
      for (md = 0; md < 3; md++)
      begin
        r = 8'($urandom());
        wr(8'h80, 8'((md | 4) << (4 * t)));
        wr(8'h90 + 8'(8 * t), 8'hFF);
        wr(8'h94 + 8'(8 * t), md == 2 ? r : 8'hFF);
        wr(8'h88, 8'(1 << (4 + 2 * t)));
        pulse(t);
        check("irq set", {31'h0, irq_o}, 32'h0000_0001);
        rd(8'h90 + 8'(8 * t), md == 2 ? r : 8'h00,
           md == 0 ? 8'h1F : 8'hFF);
        rd(8'h94 + 8'(8 * t), md == 2 ? r : 8'h00, 8'hFF);
        rd(8'h88, 8'(3 << (4 + 2 * t)), 8'hF0);
        rd(8'hA0, t == 0 ? 8'h01 : 8'h06, 8'hFF);
        rd(8'hA0, 8'h00, 8'hFF);
        check("irq clear", {31'h0, irq_o}, 32'h0000_0000);
        wr(8'h88, 8'h00);
        rd(8'h88, 8'h00, 8'hF0);
      end
    check("b pulses", n_pulse_b, 32'h0000_0003);
    // Gate and run hold the count; counting resumes from the held value
    wr(8'h80, 8'h0D);
    wr(8'h8C, 8'h08);
    wr(8'h90, 8'h00);
    pulse(0);
    rd(8'h90, 8'h00, 8'hFF);
    wr(8'h88, 8'h10);
    pulse(0);
    rd(8'h90, 8'h00, 8'hFF);
    gate_a <= 1'b1;
    repeat (6) @(posedge clk_i);
    pulse(0);
    rd(8'h90, 8'h01, 8'hFF);
    wr(8'h8C, 8'h00);
    pulse(0);
    rd(8'h90, 8'h01, 8'hFF);
    // Timer B gate follows its own input and polarity bit
    wr(8'h88, 8'h00);
    wr(8'h80, 8'hD0);
    wr(8'h8C, 8'h80);
    wr(8'h98, 8'h00);
    wr(8'h88, 8'h40);
    pulse(1);
    rd(8'h98, 8'h00, 8'hFF);
    gate_b <= 1'b1;
    repeat (6) @(posedge clk_i);
    pulse(1);
    rd(8'h98, 8'h01, 8'hFF);
    // Divide-by-4 tick over a 40-cycle run window gives exactly 10 counts
    wr(8'h88, 8'h00);
    wr(8'h84, 8'h01);
    wr(8'h80, 8'h01);
    wr(8'h90, 8'h00);
    wr(8'h94, 8'h00);
    wr(8'h88, 8'h10);
    repeat (37) @(posedge clk_i);
    wr(8'h88, 8'h00);
    rd(8'h90, 8'h0A, 8'hFF);
    // Split mode; B in mode 3 stops, high byte waits for run B
    wr(8'h84, 8'h18);
    wr(8'h80, 8'h37);
    wr(8'h90, 8'hFF);
    wr(8'h94, 8'h00);
    wr(8'h98, 8'h00);
    wr(8'h88, 8'h10);
    pulse(0);
    rd(8'h90, 8'h00, 8'hFF);
    rd(8'h94, 8'h00, 8'hFF);
    rd(8'h98, 8'h00, 8'hFF);
    rd(8'h88, 8'h30, 8'hF0);
    wr(8'h88, 8'h50);
    repeat (300) @(posedge clk_i);
    rd(8'h88, 8'h80, 8'h80);
    rd(8'h98, 8'h00, 8'hFF);
    // Split again, B in auto-reload: runs without run B, flag stays low
    wr(8'h88, 8'h10);
    rd(8'hA0, 8'h03, 8'hFF);
    wr(8'h9C, 8'hF0);
    wr(8'h80, 8'h67);
    repeat (300) @(posedge clk_i);
    rd(8'h88, 8'h10, 8'hF0);
    rd(8'hA0, 8'h04, 8'hFF);
    check("b pulses split", {31'h0, n_pulse_b > 3}, 32'h0000_0001);
    // Reset in mid-run clears control and drops the interrupt
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    check("irq reset", {31'h0, irq_o}, 32'h0000_0000);
    rd(8'h88, 8'h00, 8'hFF);
    rd(8'h9C, 8'h00, 8'hFF);
    @(posedge clk_i);
    finish_test();
  end

  // Watchdog: the tests need well under 10000 cycles
  initial
  begin
    #200_000;
    n_mismatch++;
    finish_test();
  end
endmodule
